// [design/lrx_defines.svh]
// Constants for the lane receive fabric port: register map, field
// positions, reset values and timing figures.
// Assumes inclusion by bare name from the package and every design module.
`ifndef LRX_DEFINES_SVH
`define LRX_DEFINES_SVH

`define LRX_CLK_PERIOD_NS   100
`define LRX_SETTLE_NS       500
`define LRX_SETTLE_CYC      ((`LRX_SETTLE_NS + `LRX_CLK_PERIOD_NS - 1) \
                             / `LRX_CLK_PERIOD_NS)

`define LRX_DATA_W          64
`define LRX_HDR_W           4
`define LRX_HDR66_LEN       2
`define LRX_HDR67_LEN       3
`define LRX_SF66_WORDS      32
`define LRX_SF67_WORDS      64

`define LRX_DEC_MSB         7
`define LRX_OFF_CTRL        8'h00
`define LRX_OFF_STATUS      8'h04
`define LRX_OFF_INT_STAT    8'h08
`define LRX_OFF_INT_MASK    8'h0C

`define LRX_CTRL_MODE67     0
`define LRX_CTRL_SELFRST    1
`define LRX_CTRL_RESET      32'h00000002

`define LRX_ST_INIT         0
`define LRX_ST_READY        1
`define LRX_ST_IDLE         2
`define LRX_ST_LOCK         3

`define LRX_INT_W           4
`define LRX_INT_INIT_RISE   0
`define LRX_INT_READY_FALL  1
`define LRX_INT_SF_START    2
`define LRX_INT_IDLE_RISE   3
`define LRX_INT_RESET       4'h0
`define LRX_MASK_RESET      4'h0

`endif

// [design/lrx_pkg.sv]
// Types shared by the lane receive fabric port modules.
// Assumes lrx_defines.svh is on the include path.
`include "lrx_defines.svh"

package lrx_pkg;

    typedef enum logic [3:0] {
        LRX_S_RESET  = 4'h1,
        LRX_S_WAIT   = 4'h2,
        LRX_S_SETTLE = 4'h4,
        LRX_S_VALID  = 4'h8
    } lrx_state_t;

    // Receiver analog and management status seen by the coding logic.
    typedef struct packed {
        logic cal_done;
        logic mgmt_done;
        logic cdr_lock;
        logic deser_pwr;
        logic peak_det;
    } lrx_pma_t;

    // One decoded block as delivered to the fabric.
    typedef struct packed {
        logic [`LRX_DATA_W-1:0] data;
        logic [`LRX_HDR_W-1:0]  hdr;
        logic                   hdr_valid;
        logic                   word_valid;
        logic                   sf_start;
    } lrx_rx_t;

endpackage

// [design/lrx_blk_deser.sv]
// Serial-to-block gearbox: collects the sync header and the 64 data bits
// of one block, then presents them with a one-cycle valid pulse.
// Assumes the serial stream is already aligned to block boundaries.
`timescale 1ns/1ps
`include "lrx_defines.svh"

module lrx_blk_deser
    import lrx_pkg::*;
#(
    parameter int DATA_W = `LRX_DATA_W
) (
    input  wire logic              clk_i,      // Core clock.
    input  wire logic              arst_i,     // Async reset, active high.
    input  wire logic              clr_i,      // Synchronous clear.
    input  wire logic              mode67_i,   // 1: three-bit header.
    input  wire logic              bit_en_i,   // Serial bit strobe.
    input  wire logic              bit_i,      // Serial bit.
    output logic                   blk_valid_o,// Block complete pulse.
    output logic [2:0]             hdr_o,      // Received header bits.
    output logic [DATA_W-1:0]      data_o      // Received data bits.
);

    localparam int CNT_W = $clog2(DATA_W + `LRX_HDR67_LEN);

    logic [CNT_W-1:0]  cnt_reg,   cnt_next;
    logic [2:0]        hsh_reg,   hsh_next;
    logic [DATA_W-1:0] dsh_reg,   dsh_next;
    logic              vld_reg,   vld_next;
    logic [2:0]        hdr_reg,   hdr_next;
    logic [DATA_W-1:0] dat_reg,   dat_next;
    logic [CNT_W-1:0]  hlen;
    logic [CNT_W-1:0]  last;

    always_comb begin
        hlen     = mode67_i ? CNT_W'(`LRX_HDR67_LEN) : CNT_W'(`LRX_HDR66_LEN);
        last     = CNT_W'(hlen + CNT_W'(DATA_W) - CNT_W'(1));
        cnt_next = cnt_reg;
        hsh_next = hsh_reg;
        dsh_next = dsh_reg;
        vld_next = 1'b0;
        hdr_next = hdr_reg;
        dat_next = dat_reg;
        if (clr_i) begin
            cnt_next = '0;
            hsh_next = '0;
            dsh_next = '0;
        end else if (bit_en_i) begin
            if (cnt_reg < hlen) begin
                hsh_next = {hsh_reg[1:0], bit_i};
            end else begin
                // Left shift: the first data bit on the line ends in the MSB.
                dsh_next = {dsh_reg[DATA_W-2:0], bit_i};
            end
            if (cnt_reg == last) begin
                cnt_next = '0;
                vld_next = 1'b1;
                hdr_next = hsh_reg;
                dat_next = {dsh_reg[DATA_W-2:0], bit_i};
            end else begin
                cnt_next = CNT_W'(cnt_reg + CNT_W'(1));
            end
        end
    end

    always_ff @(posedge clk_i or posedge arst_i) begin
        if (arst_i) begin
            cnt_reg <= '0;
            hsh_reg <= '0;
            dsh_reg <= '0;
            vld_reg <= 1'b0;
            hdr_reg <= '0;
            dat_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            hsh_reg <= hsh_next;
            dsh_reg <= dsh_next;
            vld_reg <= vld_next;
            hdr_reg <= hdr_next;
            dat_reg <= dat_next;
        end
    end

    assign blk_valid_o = vld_reg;
    assign hdr_o       = hdr_reg;
    assign data_o      = dat_reg;

endmodule

// [design/lrx_fabric_port.sv]
// Receive-side fabric port of one serial lane with 64b66b/64b67b coding:
// lane initialisation, decoded block delivery, super-frame marking,
// electrical-idle flag and an APB register slave with interrupt.
// Assumes one 10 MHz clock, block-aligned serial input, and that fabric
// logic drives lane_coding_reset_n_i as an async active-low reset.
`timescale 1ns/1ps
`include "lrx_defines.svh"

module lrx_fabric_port
    import lrx_pkg::*;
#(
    parameter int DATA_W     = `LRX_DATA_W,
    parameter int SETTLE_CYC = `LRX_SETTLE_CYC,
    parameter int SF66_WORDS = `LRX_SF66_WORDS,
    parameter int SF67_WORDS = `LRX_SF67_WORDS
) (
    input  wire logic              clk_i,                 // 10 MHz clock.
    input  wire logic              rst_i,                 // Async reset, high.
    input  wire logic              lane_coding_reset_n_i, // Coding reset, low.
    input  wire lrx_pma_t          pma_i,                 // Receiver status.
    input  wire logic              ser_bit_en_i,          // Serial bit strobe.
    input  wire logic              ser_bit_i,             // Serial bit.
    input  wire logic              psel_i,                // APB select.
    input  wire logic              penable_i,             // APB enable.
    input  wire logic              pwrite_i,              // APB write.
    input  wire logic [31:0]       paddr_i,               // APB address.
    input  wire logic [31:0]       pwdata_i,              // APB write data.
    output logic [31:0]            prdata_o,              // APB read data.
    output logic                   pready_o,              // APB ready.
    output logic                   pslverr_o,             // APB error.
    output logic                   irq_o,                 // Interrupt, high.
    output logic [DATA_W-1:0]      rx_data_o,             // Block data.
    output logic [`LRX_HDR_W-1:0]  rx_sync_header_o,      // Sync header.
    output logic                   rx_header_valid_o,     // Header strobe.
    output logic                   rx_word_valid_o,       // Data strobe.
    output logic                   rx_superframe_start_o, // Frame start.
    output logic                   rx_lane_initialized_o, // Lane up.
    output logic                   rx_ready_o,            // CDR clocking ok.
    output logic                   rx_idle_o              // Line idle.
);

    localparam int SET_W = $clog2(SETTLE_CYC + 1);
    localparam int SF_W  = $clog2((SF67_WORDS > SF66_WORDS ?
                                   SF67_WORDS : SF66_WORDS) + 1);

    function automatic logic reg_hit(input logic [31:0] addr,
                                     input logic [`LRX_DEC_MSB:0] off);
        reg_hit = (addr[`LRX_DEC_MSB:0] == off) &&
                  (addr[31:`LRX_DEC_MSB+1] == '0);
    endfunction

    // The coding sublayer resets on either the system or the lane reset.
    logic pcs_arst;
    assign pcs_arst = rst_i | ~lane_coding_reset_n_i;

    logic [31:0] ctrl_reg;
    logic        mode67;
    logic        self_rst;
    logic        pcs_clr;
    logic        ready_cond;
    assign mode67   = ctrl_reg[`LRX_CTRL_MODE67];
    assign self_rst = ctrl_reg[`LRX_CTRL_SELFRST];
    // A synchronous clear avoids glitching an async reset from a status bit.
    assign pcs_clr  = self_rst & ~pma_i.cdr_lock;
    // No incoming data means no fine lock, so ready drops with it.
    assign ready_cond = pma_i.cal_done & pma_i.mgmt_done &
                        pma_i.cdr_lock & pma_i.deser_pwr &
                        pma_i.peak_det;

    logic              blk_valid;
    logic [2:0]        blk_hdr;
    logic [DATA_W-1:0] blk_data;

    lrx_blk_deser #(
        .DATA_W (DATA_W)
    ) u_deser (
        .clk_i       (clk_i),
        .arst_i      (pcs_arst),
        .clr_i       (pcs_clr),
        .mode67_i    (mode67),
        .bit_en_i    (ser_bit_en_i),
        .bit_i       (ser_bit_i),
        .blk_valid_o (blk_valid),
        .hdr_o       (blk_hdr),
        .data_o      (blk_data)
    );

    // Lane initialisation and delivery on the coding reset; ready_reg sits on the system reset.
    lrx_state_t        st_reg,  st_next;
    logic [SET_W-1:0]  set_reg, set_next;
    logic [SF_W-1:0]   sf_reg,  sf_next;
    logic              ready_reg, ready_next;
    lrx_rx_t           rx_reg,  rx_next;
    logic [SF_W-1:0]   sf_len;
    logic              lane_up;

    assign lane_up = (st_reg == LRX_S_VALID);

    always_comb begin
        st_next    = st_reg;
        set_next   = set_reg;
        sf_next    = sf_reg;
        ready_next = ready_cond;
        rx_next    = rx_reg;
        sf_len     = mode67 ? SF_W'(SF67_WORDS) : SF_W'(SF66_WORDS);
        rx_next.hdr_valid  = 1'b0;
        rx_next.word_valid = 1'b0;
        rx_next.sf_start   = 1'b0;
        if (pcs_clr) begin
            st_next = LRX_S_RESET;
        end else begin
            case (st_reg)
                LRX_S_RESET: begin
                    st_next = LRX_S_WAIT;
                end
                LRX_S_WAIT: begin
                    set_next = '0;
                    if (ready_reg) begin
                        st_next = LRX_S_SETTLE;
                    end
                end
                LRX_S_SETTLE: begin
                    if (!ready_reg) begin
                        st_next = LRX_S_WAIT;
                    end else if (set_reg == SET_W'(SETTLE_CYC - 1)) begin
                        st_next = LRX_S_VALID;
                    end else begin
                        set_next = SET_W'(set_reg + SET_W'(1));
                    end
                end
                LRX_S_VALID: begin
                    if (!ready_reg) begin
                        st_next = LRX_S_WAIT;
                    end
                end
                default: begin
                    st_next = LRX_S_RESET;
                end
            endcase
        end
        if (!lane_up || pcs_clr || !ready_reg) begin
            sf_next = '0;
        end else if (blk_valid) begin
            rx_next.data       = blk_data;
            // Header right-justified; unused upper bits read zero.
            rx_next.hdr        = mode67 ? {1'b0, blk_hdr} :
                                          {2'b00, blk_hdr[1:0]};
            rx_next.hdr_valid  = 1'b1;
            rx_next.word_valid = 1'b1;
            rx_next.sf_start   = (sf_reg == '0);
            sf_next = (sf_reg >= SF_W'(sf_len - SF_W'(1))) ? '0 :
                      SF_W'(sf_reg + SF_W'(1));
        end
    end

    always_ff @(posedge clk_i or posedge pcs_arst) begin
        if (pcs_arst) begin
            st_reg    <= LRX_S_RESET;
            set_reg   <= '0;
            sf_reg    <= '0;
            rx_reg    <= '0;
        end else begin
            st_reg    <= st_next;
            set_reg   <= set_next;
            sf_reg    <= sf_next;
            rx_reg    <= rx_next;
        end
    end

    assign rx_data_o             = rx_reg.data;
    assign rx_sync_header_o      = rx_reg.hdr;
    assign rx_header_valid_o     = rx_reg.hdr_valid;
    assign rx_word_valid_o       = rx_reg.word_valid;
    assign rx_superframe_start_o = rx_reg.sf_start;
    assign rx_lane_initialized_o = lane_up;
    // Ready sits on the system reset: fabric watches it while holding the
    // coding reset, so clearing it with that reset would deadlock the lane.
    assign rx_ready_o            = ready_reg;

    // Register slave and interrupt logic, on the system reset.
    logic [31:0]            ctrl_next;
    logic [`LRX_INT_W-1:0]  ist_reg,  ist_next;
    logic [`LRX_INT_W-1:0]  msk_reg,  msk_next;
    logic [31:0]            rd_reg,   rd_next;
    logic                   err_reg,  err_next;
    logic                   idle_reg, idle_next;
    logic                   init_q,   init_q_next;
    logic                   rdy_q,    rdy_q_next;
    logic [`LRX_INT_W-1:0]  evt;
    logic [`LRX_INT_W-1:0]  rd_clr;
    logic                   setup;
    logic                   wr_acc;
    logic                   rd_ist;
    logic                   mapped;

    assign setup  = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign rd_ist = psel_i & penable_i & ~pwrite_i &
                    reg_hit(paddr_i, `LRX_OFF_INT_STAT);
    assign mapped = reg_hit(paddr_i, `LRX_OFF_CTRL) |
                    reg_hit(paddr_i, `LRX_OFF_STATUS) |
                    reg_hit(paddr_i, `LRX_OFF_INT_STAT) |
                    reg_hit(paddr_i, `LRX_OFF_INT_MASK);

    always_comb begin
        evt = '0;
        evt[`LRX_INT_INIT_RISE]  = lane_up & ~init_q;
        evt[`LRX_INT_READY_FALL] = ~ready_reg & rdy_q;
        evt[`LRX_INT_SF_START]   = rx_reg.sf_start;
        evt[`LRX_INT_IDLE_RISE]  = ~pma_i.peak_det & ~idle_reg;
    end

    // Each sticky bit lets a new event win over a read clear.
    genvar gi;
    generate
        for (gi = 0; gi < `LRX_INT_W; gi++) begin : g_int
            assign rd_clr[gi]   = rd_ist;
            assign ist_next[gi] = evt[gi] | (ist_reg[gi] & ~rd_clr[gi]);
        end
    endgenerate

    always_comb begin
        ctrl_next   = ctrl_reg;
        msk_next    = msk_reg;
        rd_next     = rd_reg;
        err_next    = err_reg;
        idle_next   = ~pma_i.peak_det;
        init_q_next = lane_up;
        rdy_q_next  = ready_reg;
        if (setup) begin
            rd_next  = '0;
            err_next = ~mapped;
            if (!pwrite_i) begin
                if (reg_hit(paddr_i, `LRX_OFF_CTRL)) begin
                    rd_next = ctrl_reg;
                end
                if (reg_hit(paddr_i, `LRX_OFF_STATUS)) begin
                    rd_next[`LRX_ST_INIT]  = lane_up;
                    rd_next[`LRX_ST_READY] = ready_reg;
                    rd_next[`LRX_ST_IDLE]  = idle_reg;
                    rd_next[`LRX_ST_LOCK]  = pma_i.cdr_lock;
                end
                if (reg_hit(paddr_i, `LRX_OFF_INT_STAT)) begin
                    rd_next[`LRX_INT_W-1:0] = ist_reg;
                end
                if (reg_hit(paddr_i, `LRX_OFF_INT_MASK)) begin
                    rd_next[`LRX_INT_W-1:0] = msk_reg;
                end
            end
        end
        if (wr_acc && reg_hit(paddr_i, `LRX_OFF_CTRL)) begin
            ctrl_next = '0;
            ctrl_next[`LRX_CTRL_MODE67]  = pwdata_i[`LRX_CTRL_MODE67];
            ctrl_next[`LRX_CTRL_SELFRST] = pwdata_i[`LRX_CTRL_SELFRST];
        end
        if (wr_acc && reg_hit(paddr_i, `LRX_OFF_INT_MASK)) begin
            msk_next = pwdata_i[`LRX_INT_W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= `LRX_CTRL_RESET;
            ist_reg  <= `LRX_INT_RESET;
            msk_reg  <= `LRX_MASK_RESET;
            rd_reg   <= '0;
            err_reg  <= 1'b0;
            idle_reg <= 1'b0;
            init_q   <= 1'b0;
            rdy_q    <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            ist_reg  <= ist_next;
            msk_reg  <= msk_next;
            rd_reg   <= rd_next;
            err_reg  <= err_next;
            idle_reg <= idle_next;
            init_q   <= init_q_next;
            rdy_q    <= rdy_q_next;
            ready_reg <= ready_next;
        end
    end

    assign prdata_o  = rd_reg;
    assign pready_o  = 1'b1;
    assign pslverr_o = err_reg & psel_i & penable_i;
    assign irq_o     = |(ist_reg & msk_reg);
    assign rx_idle_o = idle_reg;

endmodule

// [testbench/lrx_fabric_port_assertions.sv]
// Concurrent checks on the outputs of the lane receive fabric port.
// Assumes it is bound to lrx_fabric_port and sees only that module's ports.
`timescale 1ns/1ps

module lrx_fabric_port_checker
    import lrx_pkg::*;
(
    input wire logic     clk_i,                 // Clock.
    input wire logic     rst_i,                 // Reset, high.
    input wire logic     lane_coding_reset_n_i, // Coding reset, low.
    input wire lrx_pma_t pma_i,                 // Receiver status.
    input wire logic     rx_header_valid_o,     // Header strobe.
    input wire logic     rx_word_valid_o,       // Word strobe.
    input wire logic     rx_superframe_start_o, // Frame start.
    input wire logic     rx_lane_initialized_o, // Lane up.
    input wire logic     rx_ready_o,            // Clocking ok.
    input wire logic     rx_idle_o              // Line idle.
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    hdr_pair_a: assert property (
        rx_header_valid_o == rx_word_valid_o)
        else $error("Header strobe differs from word strobe.");
    word_gate_a: assert property (
        rx_word_valid_o |-> rx_lane_initialized_o)
        else $error("Word strobe while lane is down.");
    sf_word_a: assert property (
        rx_superframe_start_o |-> rx_word_valid_o)
        else $error("Frame start without a word.");
    sf_pulse_a: assert property (
        rx_superframe_start_o |=> !rx_superframe_start_o)
        else $error("Frame start longer than one cycle.");
    init_ready_a: assert property (
        rx_lane_initialized_o |-> $past(rx_ready_o))
        else $error("Lane up without receiver ready.");
    init_rise_a: assert property (
        $rose(rx_lane_initialized_o) |-> rx_ready_o && lane_coding_reset_n_i)
        else $error("Lane came up at the wrong moment.");
    idle_flag_a: assert property (
        (!pma_i.peak_det && lane_coding_reset_n_i) ##1 lane_coding_reset_n_i
        |-> rx_idle_o && !rx_ready_o)
        else $error("Idle line not flagged.");
    ready_rise_a: assert property (
        $rose(rx_ready_o) |-> &$past(pma_i))
        else $error("Ready rose without full receiver status.");
    coding_rst_a: assert property (
        !lane_coding_reset_n_i |-> !rx_lane_initialized_o && !rx_word_valid_o)
        else $error("Outputs active during coding reset.");
    self_rst_a: assert property (
        !pma_i.cdr_lock |-> ##2 !rx_lane_initialized_o)
        else $error("Lane stayed up without clock lock.");
endmodule

// [testbench/lrx_fabric_sink.sv]
// Behavioural model of the fabric logic that consumes the receive lane.
// Assumes the clock of the port and an active-high bench reset.
`timescale 1ns/1ps

module lrx_fabric_sink #(
    parameter int HOLD = 4
) (
    input  wire logic   clk_i,           // Clock.
    input  wire logic   rst_i,           // Reset, high.
    input  wire logic   rx_ready_i,      // Receiver ready.
    input  wire logic   rx_word_valid_i, // Word strobe.
    output logic        coding_rst_n_o,  // Coding reset, low.
    output logic [15:0] word_cnt_o       // Words taken.
);
    logic [3:0] hold_cnt;

    // The coding reset stays asserted while ready is low and is released
    // HOLD cycles after ready is seen high. The idle flag is never used,
    // since its detector is unreliable at high rates.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_cnt   <= 4'(HOLD);
            word_cnt_o <= 16'h0000;
        end else begin
            if (!rx_ready_i) begin
                hold_cnt <= 4'(HOLD);
            end else if (hold_cnt != 4'h0) begin
                hold_cnt <= hold_cnt - 4'h1;
            end
            if (rx_word_valid_i) begin
                word_cnt_o <= word_cnt_o + 16'h0001;
            end
        end
    end

    assign coding_rst_n_o = (hold_cnt == 4'h0);
endmodule

// [testbench/lrx_fabric_port_bench.sv]
// Self-checking bench for the lane receive fabric port.
// Assumes the design files, the sink model and the checker come first.
`timescale 1ns/1ps

module lrx_fabric_port_bench;
    localparam int SF = 4;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              crst_n;
    lrx_pkg::lrx_pma_t pma = '0;
    logic              ben = 1'b0;
    logic              bval = 1'b0;
    logic              psel = 1'b0;
    logic              pen = 1'b0;
    logic              pwr = 1'b0;
    logic [31:0]       padr = 32'h0;
    logic [31:0]       pwd = 32'h0;
    logic [31:0]       prd;
    logic              prdy;
    logic              perr;
    logic              irq;
    logic [63:0]       data;
    logic [3:0]        hdr;
    logic              hv;
    logic              wv;
    logic              sf;
    logic              init;
    logic              rdy;
    logic              idle;
    logic [15:0]       words;
    logic [31:0]       rd;
    logic              er;
    int                mismatches = 0;
    int                tests_run = 0;
    int                cycles = 0;

    lrx_fabric_port #(.SETTLE_CYC(1), .SF66_WORDS(SF), .SF67_WORDS(8)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .lane_coding_reset_n_i(crst_n),
        .pma_i(pma), .ser_bit_en_i(ben), .ser_bit_i(bval), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .irq_o(irq),
        .rx_data_o(data), .rx_sync_header_o(hdr), .rx_header_valid_o(hv),
        .rx_word_valid_o(wv), .rx_superframe_start_o(sf),
        .rx_lane_initialized_o(init), .rx_ready_o(rdy), .rx_idle_o(idle));
    lrx_fabric_sink sink (.clk_i(clk_i), .rst_i(rst_i), .rx_ready_i(rdy),
        .rx_word_valid_i(wv), .coding_rst_n_o(crst_n), .word_cnt_o(words));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        {psel, pen, pwr, padr, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_i);
        pen <= 1'b1;
        @(posedge clk_i);
        while (prdy !== 1'b1) @(posedge clk_i);
        rd = prd;
        er = perr;
        {psel, pen} <= 2'b00;
    endtask

    task automatic wait_init();
        for (int i = 0; i < 40 && init !== 1'b1; i++) @(posedge clk_i);
        #1;
    endtask

    // Sends one aligned block: header bits first, then data from bit 63.
    task automatic block_case(input int hl, input logic [2:0] h,
                              input logic [63:0] d, input logic first);
        for (int i = hl + 63; i >= 0; i--) begin
            @(posedge clk_i);
            ben  <= 1'b1;
            bval <= (i > 63) ? h[i - 64] : d[i];
        end
        @(posedge clk_i);
        ben <= 1'b0;
        for (int i = 0; i < 8 && wv !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk(64'(wv), 64'h1);
        chk(data, d);
        chk(64'(hdr), 64'(h));
        chk(64'(hv), 64'h1);
        chk(64'(sf), 64'(first));
    endtask

    task automatic t_regs();
        apb(1'b0, 32'h00, 32'h0);
        chk(64'(rd), 64'h2);
        apb(1'b0, 32'h0C, 32'h0);
        chk(64'(rd), 64'h0);
        apb(1'b1, 32'h10, 32'h0);
        chk(64'(er), 64'h1);
        chk(64'(prdy), 64'h1);
        $display("Test regs done");
    endtask

    task automatic t_init();
        @(posedge clk_i);
        // All receiver status bits, receive lock included, go high at once.
        pma <= '1;
        wait_init();
        chk(64'({init, rdy, idle, irq}), 64'hC);
        apb(1'b1, 32'h0C, 32'h1);
        #1 chk(64'(irq), 64'h1);
        apb(1'b0, 32'h08, 32'h0);
        chk(64'(rd[0]), 64'h1);
        #1 chk(64'(irq), 64'h0);
        $display("Test init done");
    endtask

    task automatic t_frames();
        for (int k = 0; k <= SF; k++) begin
            block_case(2, k[0] ? 3'h2 : 3'h1,
                       {8{k[7:0]}} ^ 64'hF0E1D2C3B4A59687, k % SF == 0);
        end
        @(posedge clk_i);
        #1 chk(64'(words), 64'(SF + 1));
        $display("Test frames done");
    endtask

    task automatic t_mode67();
        apb(1'b1, 32'h00, 32'h3);
        pma <= 5'h1A;
        @(posedge clk_i);
        #1 chk(64'({init, rdy, idle}), 64'h1);
        @(posedge clk_i);
        pma <= '1;
        wait_init();
        chk(64'(init), 64'h1);
        block_case(3, 3'h5, 64'h0123456789ABCDEF, 1'b1);
        $display("Test mode67 done");
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_init();
        t_frames();
        t_mode67();
        wrap_up();
    end
endmodule

bind lrx_fabric_port lrx_fabric_port_checker chk (
    .clk_i(clk_i), .rst_i(rst_i),
    .lane_coding_reset_n_i(lane_coding_reset_n_i), .pma_i(pma_i),
    .rx_header_valid_o(rx_header_valid_o), .rx_word_valid_o(rx_word_valid_o),
    .rx_superframe_start_o(rx_superframe_start_o),
    .rx_lane_initialized_o(rx_lane_initialized_o),
    .rx_ready_o(rx_ready_o), .rx_idle_o(rx_idle_o));
